/* File: design/rtc_cfg.svh */
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// register addresses, bank 0 and bank 1
`define ADDR_SEC        7'h00
`define ADDR_SEC_ALM    7'h01
`define ADDR_MIN        7'h02
`define ADDR_MIN_ALM    7'h03
`define ADDR_HR         7'h04
`define ADDR_HR_ALM     7'h05
`define ADDR_REG_A      7'h0a
`define ADDR_REG_B      7'h0b
`define ADDR_REG_C      7'h0c
`define ADDR_REG_D      7'h0d
`define ADDR_RAM_LO     7'h0e
`define ADDR_BANK1_REG  7'h40
`define ADDR_EXT_A      7'h4a
`define ADDR_EXT_B      7'h4b
`define ADDR_XRAM_ADDR  7'h50
`define ADDR_XRAM_DATA  7'h53

// storage sizes: 114 low bytes plus 128 extended bytes
`define RAM_BYTES       242
`define RAM_LOW_BYTES   8'h72

// reset values and fixed read values
`define RESET_DV        3'b010
`define RESET_RS        4'h6
`define RESET_REG_B     8'h02
`define REG_D_VALUE     8'h80

// flag bit positions inside the three-bit flag groups
`define FLG_UF          0
`define FLG_AF          1
`define FLG_PF          2
`define FLG_KICK        0
`define FLG_WAKE        1
`define FLG_RCLR        2

// timing
`define SYS_CLK_HZ      25000000
`define CRYSTAL_HZ      32768
`define STEP_HZ         65536
`define DIV_ACC_W       25
`define CHAIN_STATES    32768
`define CHAIN_LAST      15'h7fff
`define CHAIN_PRESET    15'h4000
`define UIP_LEAD_US     244
`define SEC_MAX         6'h3b
`define MIN_MAX         6'h3b
`define HR_MAX          5'h17
`define DONT_CARE       2'b11

`endif

/* File: design/rtc_pkg.sv */
`include "rtc_cfg.svh"
package rtc_pkg;
  typedef logic [7:0] byte_t;

  // host register port
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  // single-cycle event pulses from the other event generators
  typedef struct packed {
    logic ram_clear;
    logic wake;
    logic kick;
  } ext_events_s;

  typedef struct packed {
    logic       update_pending_flag;
    logic [2:0] dv;
    logic [3:0] rs;
  } reg_a_s;

  typedef struct packed {
    logic set;
    logic periodic_int_enable;
    logic aie;
    logic uie;
    logic square_wave_enable;
    logic dm;
    logic hr24;
    logic dse;
  } reg_b_s;

  typedef struct packed {
    reg_a_s                   ra;
    reg_b_s                   rb;
    logic [2:0]               cflag;
    logic [2:0]               xflag;
    logic [2:0]               xen;
    logic                     abe;
    logic                     fast_clock_out_enable;
    logic [7:0]               xaddr;
    byte_t [9:0]              tb;
    logic [5:0]               isec;
    logic [5:0]               imin;
    logic [4:0]               ihr;
    logic [14:0]              chain;
    logic                     clk32;
    logic                     tap_prev;
    logic                     sqw;
    logic [7:0]               rdata;
    byte_t [`RAM_BYTES-1:0]   ram;
  } rtc_state_s;

  typedef struct packed {
    logic [`DIV_ACC_W-1:0] acc;
    logic                  step;
  } div_state_s;
endpackage

/* File: design/rtc_divider.sv */
`timescale 1ns/100ps
`include "rtc_cfg.svh"
module rtc_divider #(
  parameter int CLK_HZ  = `SYS_CLK_HZ,
  parameter int STEP_HZ = `STEP_HZ
) (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_run,
  output logic      o_step
);
  import rtc_pkg::*;

  div_state_s d_reg;
  div_state_s d_next;

  // fractional accumulator, one pulse per step period on average
  always_comb begin
    int sum;
    sum         = int'(d_reg.acc) + STEP_HZ;
    d_next      = d_reg;
    d_next.step = 1'b0;
    if (i_run) begin
      if (sum >= CLK_HZ) begin
        d_next.acc  = `DIV_ACC_W'(sum - CLK_HZ);
        d_next.step = 1'b1;
      end else begin
        d_next.acc = `DIV_ACC_W'(sum);
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      d_reg <= '0;
    end else begin
      d_reg <= d_next;
    end
  end

  assign o_step = d_reg.step;
endmodule

/* File: design/rtc_irq_sqw.sv */
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "rtc_cfg.svh"
module rtc_irq_sqw (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset,
  input  wire rtc_pkg::bus_req_s    i_bus,
  output logic [7:0]                o_rdata,
  input  wire rtc_pkg::ext_events_s i_events,
  input  wire logic                 i_main_supply_ok,
  input  wire logic                 i_auxiliary_supply,
  output logic                      o_irq_o,
  output logic                      o_irq_oe_n,
  output logic                      o_square_wave_pin,
  output logic                      o_update_pending_flag
);
  import rtc_pkg::*;

  localparam int LEAD_TICKS = (`UIP_LEAD_US * `CRYSTAL_HZ + 999999) / 1000000;
  localparam logic [14:0] UIP_START = 15'(`CHAIN_STATES - LEAD_TICKS);
  localparam rtc_state_s STATE_RST = '{
    ra: '{update_pending_flag: 1'b0, dv: `RESET_DV, rs: `RESET_RS},
    rb: reg_b_s'(`RESET_REG_B),
    default: '0
  };

  rtc_state_s s_reg;
  rtc_state_s s_next;
  logic       step;
  logic       osc_run;
  logic       chain_hold;
  logic       bank1;
  logic       irq_active;
  logic       full_tick;
  logic       tap;
  logic [3:0] tap_idx;
  logic [2:0] en_c;
  logic [7:0] rd_val;
  logic [7:0] ram_lo_idx;
  logic [7:0] xram_idx;
  logic       ext_space;

  // divider control decode
  assign osc_run    = s_reg.ra.dv[1];
  assign chain_hold = s_reg.ra.dv[2] & s_reg.ra.dv[1];
  assign bank1      = s_reg.ra.dv[0];

  // interrupt aggregation
  assign en_c       = {s_reg.rb.periodic_int_enable, s_reg.rb.aie, s_reg.rb.uie};
  assign irq_active = (|(s_reg.cflag & en_c)) | (|(s_reg.xflag & s_reg.xen));

  rtc_divider #(
    .CLK_HZ  (`SYS_CLK_HZ),
    .STEP_HZ (`STEP_HZ)
  ) u_div (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_run     (osc_run),
    .o_step    (step)
  );

  // chain advances on the falling half of the 32 kHz phase
  assign full_tick = step & s_reg.clk32;

  // rate select to divider tap
  always_comb begin
    case (s_reg.ra.rs)
      4'h1, 4'h8: tap_idx = 4'h6;
      4'h2, 4'h9: tap_idx = 4'h7;
      4'h3:       tap_idx = 4'h1;
      4'h4:       tap_idx = 4'h2;
      4'h5:       tap_idx = 4'h3;
      4'h6:       tap_idx = 4'h4;
      4'h7:       tap_idx = 4'h5;
      4'ha:       tap_idx = 4'h8;
      4'hb:       tap_idx = 4'h9;
      4'hc:       tap_idx = 4'ha;
      4'hd:       tap_idx = 4'hb;
      4'he:       tap_idx = 4'hc;
      4'hf:       tap_idx = 4'hd;
      default:    tap_idx = 4'h0;
    endcase
  end
  assign tap = (s_reg.ra.rs != 4'h0) & s_reg.chain[tap_idx];

  // address to storage index
  assign ram_lo_idx = {1'b0, i_bus.addr} - {1'b0, `ADDR_RAM_LO};
  assign xram_idx   = `RAM_LOW_BYTES + {1'b0, s_reg.xaddr[6:0]};
  assign ext_space  = bank1 & (i_bus.addr >= `ADDR_BANK1_REG);

  function automatic logic alarm_hit(input logic [7:0] alm, input logic [7:0] t);
    return (alm[7:6] == `DONT_CARE) || (alm == t);
  endfunction

  // read multiplexer
  always_comb begin
    rd_val = 8'h00;
    if (i_bus.addr < `ADDR_REG_A) begin
      rd_val = s_reg.tb[i_bus.addr[3:0]];
    end else if (i_bus.addr == `ADDR_REG_A) begin
      rd_val = s_reg.ra;
    end else if (i_bus.addr == `ADDR_REG_B) begin
      rd_val = s_reg.rb;
    end else if (i_bus.addr == `ADDR_REG_C) begin
      rd_val = {irq_active, s_reg.cflag, 4'h0};
    end else if (i_bus.addr == `ADDR_REG_D) begin
      rd_val = `REG_D_VALUE;
    end else if (!ext_space) begin
      rd_val = s_reg.ram[ram_lo_idx];
    end else begin
      case (i_bus.addr)
        `ADDR_EXT_A:     rd_val = {5'h00, s_reg.xflag};
        `ADDR_EXT_B:     rd_val = {s_reg.abe, s_reg.fast_clock_out_enable, 3'h0, s_reg.xen};
        `ADDR_XRAM_ADDR: rd_val = s_reg.xaddr;
        `ADDR_XRAM_DATA: rd_val = s_reg.ram[xram_idx];
        default:         rd_val = 8'h00;
      endcase
    end
  end

  // next state: host access, then timebase, then event sets
  always_comb begin
    logic [5:0] sec_n;
    logic [5:0] min_n;
    logic [4:0] hr_n;
    sec_n        = s_reg.isec;
    min_n        = s_reg.imin;
    hr_n         = s_reg.ihr;
    s_next       = s_reg;
    s_next.rdata = 8'h00;
    // host read, register C clears after capture
    if (i_bus.rd) begin
      s_next.rdata = rd_val;
      if (i_bus.addr == `ADDR_REG_C) begin
        s_next.cflag = 3'b000;
      end
    end
    // host write
    if (i_bus.wr) begin
      if (i_bus.addr < `ADDR_REG_A) begin
        s_next.tb[i_bus.addr[3:0]] = i_bus.wdata;
        case (i_bus.addr)
          `ADDR_SEC: s_next.isec = i_bus.wdata[5:0];
          `ADDR_MIN: s_next.imin = i_bus.wdata[5:0];
          `ADDR_HR:  s_next.ihr  = i_bus.wdata[4:0];
          default:   s_next.isec = s_next.isec;
        endcase
      end else if (i_bus.addr == `ADDR_REG_A) begin
        s_next.ra.dv = i_bus.wdata[6:4];
        s_next.ra.rs = i_bus.wdata[3:0];
      end else if (i_bus.addr == `ADDR_REG_B) begin
        s_next.rb = reg_b_s'(i_bus.wdata);
        if (i_bus.wdata[7]) begin
          s_next.ra.update_pending_flag = 1'b0;
          if (!s_reg.rb.set) begin
            s_next.rb.uie = 1'b0;
          end
        end
      end else if ((i_bus.addr == `ADDR_REG_C) || (i_bus.addr == `ADDR_REG_D)) begin
        s_next.rdata = 8'h00;                            // read-only registers
      end else if (!ext_space) begin
        s_next.ram[ram_lo_idx] = i_bus.wdata;
      end else begin
        case (i_bus.addr)
          `ADDR_EXT_A: s_next.xflag = s_reg.xflag & i_bus.wdata[2:0];
          `ADDR_EXT_B: begin
            s_next.abe  = i_bus.wdata[7];
            s_next.fast_clock_out_enable = i_bus.wdata[6];
            s_next.xen  = i_bus.wdata[2:0];
          end
          `ADDR_XRAM_ADDR: s_next.xaddr = i_bus.wdata;
          `ADDR_XRAM_DATA: s_next.ram[xram_idx] = i_bus.wdata;
          default:         s_next.xaddr = s_next.xaddr;
        endcase
      end
    end
    // 32 kHz phase and countdown chain
    if (step) begin
      s_next.clk32 = ~s_reg.clk32;
    end
    if (chain_hold) begin
      s_next.chain  = `CHAIN_PRESET;
      s_next.ra.update_pending_flag = 1'b0;
    end else if (full_tick) begin
      s_next.chain = s_reg.chain + 15'h0001;
      if ((s_reg.chain == UIP_START) && !s_next.rb.set) begin
        s_next.ra.update_pending_flag = 1'b1;
      end
      if (s_reg.chain == `CHAIN_LAST) begin
        // once-per-second update of the internal copy
        s_next.ra.update_pending_flag = 1'b0;
        if (s_reg.isec >= `SEC_MAX) begin
          sec_n = 6'h00;
          if (s_reg.imin >= `MIN_MAX) begin
            min_n = 6'h00;
            hr_n  = (s_reg.ihr >= `HR_MAX) ? 5'h00 : s_reg.ihr + 5'h01;
          end else begin
            min_n = s_reg.imin + 6'h01;
          end
        end else begin
          sec_n = s_reg.isec + 6'h01;
        end
        s_next.isec = sec_n;
        s_next.imin = min_n;
        s_next.ihr  = hr_n;
        if (alarm_hit(s_reg.tb[`ADDR_SEC_ALM], {2'b00, sec_n}) &&
            alarm_hit(s_reg.tb[`ADDR_MIN_ALM], {2'b00, min_n}) &&
            alarm_hit(s_reg.tb[`ADDR_HR_ALM], {3'b000, hr_n})) begin
          s_next.cflag[`FLG_AF] = 1'b1;
        end
        // transfer to host copy only outside set mode
        if (!s_next.rb.set) begin
          s_next.tb[`ADDR_SEC] = {2'b00, sec_n};
          s_next.tb[`ADDR_MIN] = {2'b00, min_n};
          s_next.tb[`ADDR_HR]  = {3'b000, hr_n};
          s_next.cflag[`FLG_UF] = 1'b1;
        end
      end
    end
    // periodic flag on each rising edge of the selected tap
    s_next.tap_prev = tap;
    if (tap && !s_reg.tap_prev) begin
      s_next.cflag[`FLG_PF] = 1'b1;
    end
    // external events win over a same-cycle clear
    s_next.xflag = s_next.xflag | {i_events.ram_clear, i_events.wake, i_events.kick};
    // square wave selection
    if (!osc_run) begin
      s_next.sqw = 1'b0;
    end else if (!i_main_supply_ok) begin
      s_next.sqw = s_reg.fast_clock_out_enable & s_reg.abe & i_auxiliary_supply & s_reg.clk32;
    end else if (s_reg.fast_clock_out_enable) begin
      s_next.sqw = s_reg.clk32;
    end else begin
      s_next.sqw = s_reg.rb.square_wave_enable & tap;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs; open-drain request only ever drives low
  assign o_rdata               = s_reg.rdata;
  assign o_irq_o               = 1'b0;
  assign o_irq_oe_n            = ~irq_active;
  assign o_square_wave_pin     = s_reg.sqw;
  assign o_update_pending_flag = s_reg.ra.update_pending_flag;

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  property p_irq_drive;
    (i_events.wake && s_reg.xen[`FLG_WAKE] && !(i_bus.wr && i_bus.addr == `ADDR_EXT_B))
      |=> (!o_irq_oe_n && !o_irq_o);
  endproperty
  a_irq_drive: assert property (p_irq_drive) else $error("wake event did not pull request");

  property p_enable_now;
    (i_bus.wr && i_bus.addr == `ADDR_REG_B && i_bus.wdata[6] && s_reg.cflag[`FLG_PF])
      |=> !o_irq_oe_n;
  endproperty
  a_enable_now: assert property (p_enable_now) else $error("enable on set flag not immediate");

  property p_block;
    (s_reg.cflag != 3'b000 && en_c == 3'b000 && (s_reg.xflag & s_reg.xen) == 3'b000)
      |-> o_irq_oe_n;
  endproperty
  a_block: assert property (p_block) else $error("request driven with no enabled flag");

  property p_read_clear;
    (i_bus.rd && i_bus.addr == `ADDR_REG_C && !full_tick && !(tap && !s_reg.tap_prev))
      |=> (s_reg.cflag == 3'b000);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flags not cleared by read");

  property p_read_stable;
    (i_bus.rd && i_bus.addr == `ADDR_REG_C)
      |=> (o_rdata[6:4] == $past(s_reg.cflag) && o_rdata[7] == $past(irq_active));
  endproperty
  a_read_stable: assert property (p_read_stable) else $error("flag read data wrong");

  property p_ext_sticky;
    (i_bus.rd && i_bus.addr == `ADDR_EXT_A) |=> (s_reg.xflag == ($past(s_reg.xflag) | $past(i_events)));
  endproperty
  a_ext_sticky: assert property (p_ext_sticky) else $error("extended flags changed on read");

  property p_event_flag;
    i_events.kick |=> s_reg.xflag[`FLG_KICK] [*1];
  endproperty
  a_event_flag: assert property (p_event_flag) else $error("kick flag not set");

  property p_fast_clk;
    (i_main_supply_ok && s_reg.fast_clock_out_enable && osc_run) |=> (o_square_wave_pin == $past(s_reg.clk32));
  endproperty
  a_fast_clk: assert property (p_fast_clk) else $error("fast clock not on square wave pin");

  property p_supply_loss;
    (!i_main_supply_ok && !(s_reg.fast_clock_out_enable && s_reg.abe && i_auxiliary_supply)) |=> !o_square_wave_pin;
  endproperty
  a_supply_loss: assert property (p_supply_loss) else $error("square wave during supply loss");

  property p_set_uip;
    (i_bus.wr && i_bus.addr == `ADDR_REG_B && i_bus.wdata[7]) |=> !o_update_pending_flag [*2];
  endproperty
  a_set_uip: assert property (p_set_uip) else $error("update pending survived set mode");

  property p_chain_hold;
    chain_hold |=> (s_reg.chain == `CHAIN_PRESET && !o_update_pending_flag);
  endproperty
  a_chain_hold: assert property (p_chain_hold) else $error("chain not held in reset");

  c_irq:    cover property (o_irq_oe_n ##1 !o_irq_oe_n);
  c_update: cover property (o_update_pending_flag ##[1:300] s_reg.cflag[`FLG_UF]);
  c_pf:     cover property ($rose(s_reg.cflag[`FLG_PF]));
  c_sqw:    cover property ($rose(o_square_wave_pin) && !s_reg.fast_clock_out_enable);
endmodule

/* File: dv/rtc_host_model.sv */
`timescale 1ns/100ps
// host side of the register port: one-cycle strobes, no wait states
module rtc_host_model (
  input  wire logic          i_sys_clk,
  output rtc_pkg::bus_req_s  o_bus
);
  import rtc_pkg::*;

  // idle bus from time zero
  initial begin
    o_bus = '0;
  end

  // single write cycle; data lines scrambled once the strobe drops
  task automatic wr(input logic [6:0] a, input byte_t d);
    @(posedge i_sys_clk);
    o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_sys_clk);
    o_bus.wr    <= 1'b0;
    o_bus.wdata <= ~d;
  endtask

  // single read cycle; data is taken by the bench in the next cycle
  task automatic rd(input logic [6:0] a);
    @(posedge i_sys_clk);
    o_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_sys_clk);
    o_bus.rd <= 1'b0;
  endtask
endmodule

/* File: dv/rtc_irq_sqw_tb.sv */
`timescale 1ns/100ps
`include "rtc_cfg.svh"
module rtc_irq_sqw_tb;
  import rtc_pkg::*;

  logic                i_sys_clk = 1'b0;
  logic                i_reset   = 1'b1;
  bus_req_s            bus;
  logic [7:0]          rdata;
  ext_events_s         events    = '0;
  logic                main_ok   = 1'b1;
  logic                aux_ok    = 1'b0;
  logic                irq_o;
  logic                irq_oe_n;
  logic                sqw;
  logic                update_pending_flag;
  logic                rd_prev   = 1'b0;
  int                  n_fail    = 0;
  int                  num_checks = 0;
  int                  cycles    = 0;
  byte_t               exp_q[$];
  byte_t               v [4];

  // open-drain request line with pull-up
  wire irq_wire = irq_oe_n ? 1'b1 : irq_o;

  always #20 i_sys_clk = ~i_sys_clk;

  rtc_host_model host (.i_sys_clk(i_sys_clk), .o_bus(bus));

  rtc_irq_sqw DUT (
    .i_sys_clk             (i_sys_clk),
    .i_reset               (i_reset),
    .i_bus                 (bus),
    .o_rdata               (rdata),
    .i_events              (events),
    .i_main_supply_ok      (main_ok),
    .i_auxiliary_supply    (aux_ok),
    .o_irq_o               (irq_o),
    .o_irq_oe_n            (irq_oe_n),
    .o_square_wave_pin     (sqw),
    .o_update_pending_flag (update_pending_flag)
  );

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask

  // note the expected byte, then issue the read
  task automatic rd_chk(input logic [6:0] a, input byte_t e);
    exp_q.push_back(e);
    host.rd(a);
  endtask

  // request line level, sampled once the edge has settled
  task automatic chk_irq(input logic e);
    @(posedge i_sys_clk);
    #1;
    chk_bit(irq_wire, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // one-cycle event pulse on source i
  task automatic pulse(input int i);
    @(posedge i_sys_clk);
    events <= ext_events_s'(3'b001 << i);
    @(posedge i_sys_clk);
    events <= '0;
  endtask

  // set up the output path, then count pin transitions over 4000 cycles
  task automatic sqw_case(input byte_t a, input byte_t b, input byte_t xb, input logic m,
                          input logic x, input int lo, input int hi);
    int   c;
    logic last;
    c = 0;
    host.wr(`ADDR_EXT_B, xb);
    host.wr(`ADDR_REG_B, b);
    host.wr(`ADDR_REG_A, a);
    @(posedge i_sys_clk);
    main_ok <= m;
    aux_ok  <= x;
    idle(20);
    last = sqw;
    repeat (4000) begin
      @(posedge i_sys_clk);
      if (sqw !== last) c++;
      last = sqw;
    end
    chk_bit((c >= lo) && (c <= hi), 1'b1);
  endtask

  // hang guard, tests need about 48400 cycles
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      n_fail++;
      give_verdict();
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge i_sys_clk) begin
    if (rd_prev) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, rdata, 8'h00);
      end else begin
        chk(rdata, exp_q.pop_front());
      end
    end
    rd_prev <= bus.rd;
  end

  initial begin
    void'($urandom(32'h8e0b));
    idle(10);
    i_reset <= 1'b0;
    idle(1);
    // reset values of the control registers
    rd_chk(`ADDR_REG_A, 8'h26);
    rd_chk(`ADDR_REG_B, 8'h02);
    rd_chk(`ADDR_REG_C, 8'h00);
    rd_chk(`ADDR_REG_D, 8'h80);
    chk_bit(update_pending_flag, 1'b0);
    chk_bit(irq_wire, 1'b1);
    $display("test reset done");
    // low and extended ram, both banks
    foreach (v[k]) v[k] = byte_t'($urandom());
    host.wr(`ADDR_RAM_LO, v[0]);
    host.wr(7'h7f, v[1]);
    rd_chk(`ADDR_RAM_LO, v[0]);
    rd_chk(7'h7f, v[1]);
    host.wr(`ADDR_REG_A, 8'h36);
    rd_chk(`ADDR_REG_A, 8'h36);
    host.wr(`ADDR_XRAM_ADDR, 8'h7f);
    host.wr(`ADDR_XRAM_DATA, v[2]);
    host.wr(`ADDR_XRAM_ADDR, 8'h00);
    host.wr(`ADDR_XRAM_DATA, v[3]);
    rd_chk(`ADDR_XRAM_DATA, v[3]);
    host.wr(`ADDR_XRAM_ADDR, 8'h7f);
    rd_chk(`ADDR_XRAM_DATA, v[2]);
    rd_chk(`ADDR_RAM_LO, v[0]);
    rd_chk(`ADDR_REG_B, 8'h02);
    rd_chk(7'h60, 8'h00);
    $display("test ram done");
    // each extended source: flag while disabled, enable, clear by writing 0
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      chk_irq(1'b1);
      rd_chk(`ADDR_EXT_A, byte_t'(1 << i));
      host.wr(`ADDR_EXT_B, byte_t'(1 << i));
      chk_irq(1'b0);
      rd_chk(`ADDR_REG_C, 8'h80);
      rd_chk(`ADDR_EXT_A, byte_t'(1 << i));
      pulse(i);
      chk_irq(1'b0);
      host.wr(`ADDR_EXT_A, 8'h00);
      chk_irq(1'b1);
      host.wr(`ADDR_EXT_B, 8'h00);
    end
    $display("test extended sources done");
    // periodic flag polled, then enabled
    host.wr(`ADDR_REG_C, 8'hff);
    rd_chk(`ADDR_REG_C, 8'h00);
    host.wr(`ADDR_REG_A, 8'h33);
    idle(4000);
    host.wr(`ADDR_REG_A, 8'h30);
    rd_chk(`ADDR_REG_C, 8'h40);
    rd_chk(`ADDR_REG_C, 8'h00);
    host.wr(`ADDR_REG_A, 8'h33);
    idle(4000);
    host.wr(`ADDR_REG_A, 8'h30);
    chk_irq(1'b1);
    host.wr(`ADDR_REG_B, 8'h42);
    chk_irq(1'b0);
    rd_chk(`ADDR_REG_C, 8'hc0);
    chk_irq(1'b1);
    host.wr(`ADDR_REG_B, 8'h02);
    $display("test periodic done");
    // set mode: pending flag low, time byte held as written
    host.wr(`ADDR_REG_B, 8'h82);
    chk_bit(update_pending_flag, 1'b0);
    host.wr(`ADDR_SEC, 8'h15);
    rd_chk(`ADDR_SEC, 8'h15);
    rd_chk(`ADDR_REG_B, 8'h82);
    $display("test set mode done");
    // square wave paths
    sqw_case(8'h36, 8'h02, 8'h00, 1'b1, 1'b0, 0, 0);
    sqw_case(8'h36, 8'h02, 8'h40, 1'b1, 1'b0, 9, 11);
    sqw_case(8'h33, 8'h0a, 8'h00, 1'b1, 1'b0, 2, 3);
    sqw_case(8'h3f, 8'h0a, 8'h00, 1'b1, 1'b0, 0, 0);
    sqw_case(8'h73, 8'h0a, 8'h00, 1'b1, 1'b0, 0, 0);
    sqw_case(8'h16, 8'h02, 8'h40, 1'b1, 1'b0, 0, 0);
    sqw_case(8'h36, 8'h02, 8'hc0, 1'b0, 1'b1, 9, 11);
    sqw_case(8'h36, 8'h02, 8'hc0, 1'b0, 1'b0, 0, 0);
    sqw_case(8'h36, 8'h02, 8'h40, 1'b0, 1'b1, 0, 0);
    sqw_case(8'h33, 8'h0a, 8'h80, 1'b0, 1'b1, 0, 0);
    $display("test square wave done");
    give_verdict();
  end
endmodule
